// File: inc/tbms_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tbms_link_if;
   logic host_pulse_control_input;
   logic serial_result_output;
   modport dev (input host_pulse_control_input, output serial_result_output);
   modport hst (output host_pulse_control_input, input serial_result_output);
endinterface
`default_nettype wire

// File: inc/tbms_pkg.sv
package tbms_pkg;
   typedef enum logic [2:0] {
      S_IDLE, S_PROG, S_CHARGE, S_WRITE, S_RECHG, S_READ, S_SLEEP
   } tbms_state_t;
   typedef enum logic [1:0] {H_IDLE, H_FRAME, H_LOW, H_SCLK} tbms_hstate_t;
endpackage

// File: inc/tbms_regs.svh
`ifndef TBMS_REGS_SVH
`define TBMS_REGS_SVH
// clock and serial timing
`define TBMS_MCLK_MHZ 50
`define TBMS_BIT_US 64
`define TBMS_WR_DLY_US 1
// device sequencer times
`define TBMS_DIAG_US 2000
`define TBMS_READ_MAX_US 20000
`define TBMS_SLEEP_US 100000
`define TBMS_STOP_US 128
`define TBMS_WEND_US 1000
`define TBMS_LCHG_US 15000
// host pulse times
`define TBMS_HCHG_US 10000
`define TBMS_HLCHG_US 30000
`define TBMS_HSTOP_US 200
`define TBMS_HSCLK_US 8
// stored mode field positions (frame bit n sits at n-1)
`define TBMS_MODE_SYNC 4
`define TBMS_MODE_AFC 5
`define TBMS_MODE_TEST 6
// divider factors and diagnosis bytes
`define TBMS_DIV_DEF 8'h77
`define TBMS_DIV_114 8'h72
`define TBMS_DIV_115 8'h73
`define TBMS_DIV_124 8'h7c
`define TBMS_DIAG_OK 8'haf
`define TBMS_DIAG_FAIL 8'hff
// host register offsets (bytes) and command bits
`define TBMS_REG_CMD 5'h00
`define TBMS_REG_MODE 5'h04
`define TBMS_REG_LEVEL 5'h08
`define TBMS_REG_STATUS 5'h0c
`define TBMS_REG_RXDATA 5'h10
`define TBMS_CMD_FRAME 0
`define TBMS_CMD_CHARGE 1
`define TBMS_CMD_STOP 2
`define TBMS_CMD_SCLK 3
`define TBMS_CMD_LONG 4
`endif

// File: rtl/tbms_device.sv
// Function
// R1: default mode drives bridge at default carrier
// R2: unprogrammed mode register holds all zeros
// R3: host holds control low to start charge
// R4: rise after charge enters read, sends data
// R5: second read mode programs register first
// R6: write-read: program register, then charge
// R7: write phase keys carrier with fixed delay
// R8: low again recharges; rise enters read
// R9: frame start bit is zero, not stored
// R10: divider bits pick factor 114 to 124; only codes 1, 2 and b are decoded, all others but f give default 119
// R11: all-ones divider bits select automatic factor
// R12: bit 5 picks async or clocked output
// R13: bit 6 picks demodulator threshold source
// R14: bit 7 announces following test byte
// R15: automatic mode loads measured count into divider
// R16: host avoids all-ones without measurement
// R17: host keeps test bits zero
// R18: sequencer sends diagnosis byte during charge
// R19: state timeouts count from state entry
// R20: logic probe output exposes internal state
// R21: async byte lsb first, high start, inverted
// R22: diagnosis byte 2 ms into charge
// R23: sync: output high flags byte, host clocks
// R24: host low 128 us stops read phase
`timescale 1ns/1ps
`include "tbms_regs.svh"
`default_nettype none
module tbms_device #(
   parameter int DIAG_CYC = `TBMS_DIAG_US * `TBMS_MCLK_MHZ,
   parameter int READ_CYC = `TBMS_READ_MAX_US * `TBMS_MCLK_MHZ,
   parameter int SLEEP_CYC = `TBMS_SLEEP_US * `TBMS_MCLK_MHZ,
   parameter int STOP_CYC = `TBMS_STOP_US * `TBMS_MCLK_MHZ,
   parameter int WEND_CYC = `TBMS_WEND_US * `TBMS_MCLK_MHZ,
   parameter int LCHG_CYC = `TBMS_LCHG_US * `TBMS_MCLK_MHZ
) (
   input wire logic mclk,
   input wire logic rst,
   tbms_link_if.dev lnk,
   input wire logic meas_valid,
   input wire logic [7:0] meas_count,
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   input wire logic osc_ok,
   input wire logic short_fault,
   output logic carrier_on,
   output logic [7:0] div_factor,
   output logic threshold_source_select,
   output logic [3:0] threshold_code,
   output logic clocked_output_select,
   output logic test_follow,
   output logic logic_probe_output,
   output logic read_active
);
   localparam int BIT_CYC = `TBMS_BIT_US * `TBMS_MCLK_MHZ;
   localparam int HALF_CYC = BIT_CYC / 2;
   localparam int WDLY_CYC = `TBMS_WR_DLY_US * `TBMS_MCLK_MHZ;

   tbms_pkg::tbms_state_t st_ff;
   logic [23:0] tmr_ff;
   logic [23:0] low_ff;
   logic [3:0] bcnt_ff;
   logic [7:0] frm_ff;
   logic [6:0] mode_ff;
   logic ctl_d_ff;
   logic [WDLY_CYC-1:0] dly_ff;
   logic [7:0] hold_ff;
   logic hold_v_ff;
   logic [7:0] sh_ff;
   logic [3:0] idx_ff;
   logic [11:0] ttmr_ff;
   logic busy_ff;
   logic sro_ff;
   logic ctl;
   logic fall;
   logic rise;
   logic diag_go;
   logic ld_rx;
   logic sync_m;

   assign ctl = lnk.host_pulse_control_input;
   assign fall = ctl_d_ff & ~ctl;
   assign rise = ~ctl_d_ff & ctl;
   assign sync_m = mode_ff[`TBMS_MODE_SYNC];
   assign diag_go = (st_ff == tbms_pkg::S_CHARGE) &&
                    (tmr_ff == 24'(DIAG_CYC)); // [R18] [R22]
   assign ld_rx = (st_ff == tbms_pkg::S_READ) && hold_v_ff && !busy_ff;
   assign lnk.serial_result_output = sro_ff;

   // control line edge and low-time tracking
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctl_d_ff <= 1'b1;
         low_ff <= 24'h0;
      end else begin
         ctl_d_ff <= ctl;
         if (ctl) begin
            low_ff <= 24'h0;
         end else if (low_ff != 24'hffffff) begin
            low_ff <= low_ff + 24'h1;
         end
      end
   end

   // sequencer with mode register
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_ff <= tbms_pkg::S_IDLE;
         tmr_ff <= 24'h0;
         bcnt_ff <= 4'h0;
         frm_ff <= 8'h0;
         mode_ff <= 7'h0; // [R2]
      end else begin
         tmr_ff <= tmr_ff + 24'h1; // [R19]
         case (st_ff)
            tbms_pkg::S_IDLE, tbms_pkg::S_SLEEP: begin
               if (fall) begin
                  st_ff <= tbms_pkg::S_PROG; // [R3]
                  tmr_ff <= 24'h0;
                  bcnt_ff <= 4'h0;
               end else if (st_ff == tbms_pkg::S_IDLE &&
                            tmr_ff >= 24'(SLEEP_CYC)) begin
                  st_ff <= tbms_pkg::S_SLEEP;
                  tmr_ff <= 24'h0;
               end
            end
            tbms_pkg::S_PROG: begin
               if (tmr_ff == 24'(HALF_CYC)) begin
                  if (bcnt_ff == 4'h8) begin
                     tmr_ff <= 24'h0;
                     if (ctl) begin
                        mode_ff <= frm_ff[7:1]; // [R9] [R5] [R6]
                        st_ff <= tbms_pkg::S_IDLE;
                     end else begin
                        st_ff <= tbms_pkg::S_CHARGE; // [R3] [R1]
                     end
                  end else begin
                     frm_ff[bcnt_ff[2:0]] <= ctl;
                  end
               end
               if (tmr_ff == 24'(BIT_CYC - 1)) begin
                  tmr_ff <= 24'h0;
                  bcnt_ff <= bcnt_ff + 4'h1;
               end
            end
            tbms_pkg::S_CHARGE: begin
               if (rise) begin
                  tmr_ff <= 24'h0;
                  if (tmr_ff >= 24'(LCHG_CYC)) begin
                     st_ff <= tbms_pkg::S_WRITE; // [R6]
                  end else begin
                     st_ff <= tbms_pkg::S_READ; // [R4]
                  end
               end
            end
            tbms_pkg::S_WRITE: begin
               if (low_ff >= 24'(WEND_CYC)) begin
                  st_ff <= tbms_pkg::S_RECHG; // [R8]
                  tmr_ff <= 24'h0;
               end
            end
            tbms_pkg::S_RECHG: begin
               if (rise) begin
                  st_ff <= tbms_pkg::S_READ; // [R8]
                  tmr_ff <= 24'h0;
               end
            end
            tbms_pkg::S_READ: begin
               if (tmr_ff >= 24'(READ_CYC) || low_ff >= 24'(STOP_CYC)) begin
                  st_ff <= tbms_pkg::S_IDLE; // [R24]
                  tmr_ff <= 24'h0;
               end
            end
            default: begin
               st_ff <= tbms_pkg::S_IDLE;
               tmr_ff <= 24'h0;
            end
         endcase
      end
   end

   // carrier keying, write data delayed by a fixed pipe
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         dly_ff <= '0;
         carrier_on <= 1'b0;
      end else begin
         dly_ff <= {dly_ff[WDLY_CYC-2:0], ctl};
         case (st_ff)
            tbms_pkg::S_CHARGE, tbms_pkg::S_RECHG: carrier_on <= 1'b1;
            tbms_pkg::S_WRITE: carrier_on <= dly_ff[WDLY_CYC-1]; // [R7]
            default: carrier_on <= 1'b0;
         endcase
      end
   end

   // divider factor and mode outputs
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         div_factor <= `TBMS_DIV_DEF; // [R1]
         threshold_source_select <= 1'b0;
         threshold_code <= 4'h0;
         clocked_output_select <= 1'b0;
         test_follow <= 1'b0;
      end else begin
         case (mode_ff[3:0]) // [R10]
            4'h0, 4'h6: div_factor <= `TBMS_DIV_DEF;
            4'h1: div_factor <= `TBMS_DIV_114;
            4'h2: div_factor <= `TBMS_DIV_115;
            4'hb: div_factor <= `TBMS_DIV_124;
            4'hf: begin
               if (meas_valid) begin
                  div_factor <= meas_count; // [R11] [R15]
               end
            end
            default: div_factor <= `TBMS_DIV_DEF;
         endcase
         threshold_source_select <= mode_ff[`TBMS_MODE_AFC]; // [R13]
         threshold_code <= mode_ff[3:0];
         clocked_output_select <= sync_m; // [R12]
         test_follow <= mode_ff[`TBMS_MODE_TEST]; // [R14]
      end
   end

   // received byte holding register
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         hold_ff <= 8'h0;
         hold_v_ff <= 1'b0;
      end else if (rx_valid && st_ff == tbms_pkg::S_READ) begin
         hold_ff <= rx_byte;
         hold_v_ff <= 1'b1;
      end else if (ld_rx) begin
         hold_v_ff <= 1'b0;
      end
   end

   // serial encoder, async or host clocked
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sh_ff <= 8'h0;
         idx_ff <= 4'h0;
         ttmr_ff <= 12'h0;
         busy_ff <= 1'b0;
         sro_ff <= 1'b0;
      end else if (diag_go || ld_rx) begin
         if (diag_go) begin
            sh_ff <= (osc_ok && !short_fault) ? `TBMS_DIAG_OK :
                     `TBMS_DIAG_FAIL; // [R22]
         end else begin
            sh_ff <= hold_ff; // [R4]
         end
         idx_ff <= 4'h0;
         ttmr_ff <= 12'h0;
         busy_ff <= 1'b1;
         sro_ff <= 1'b1; // [R21] [R23]
      end else if (busy_ff && !sync_m) begin
         ttmr_ff <= ttmr_ff + 12'h1;
         if (ttmr_ff == 12'(BIT_CYC - 1)) begin
            ttmr_ff <= 12'h0;
            idx_ff <= idx_ff + 4'h1;
            if (idx_ff < 4'h8) begin
               sro_ff <= ~sh_ff[idx_ff[2:0]]; // [R21]
            end else if (idx_ff == 4'h8) begin
               sro_ff <= 1'b0;
            end else begin
               busy_ff <= 1'b0;
            end
         end
      end else if (busy_ff) begin
         if (fall && idx_ff < 4'h8) begin
            sro_ff <= ~sh_ff[idx_ff[2:0]]; // [R23]
            idx_ff <= idx_ff + 4'h1;
         end else if (rise && idx_ff == 4'h8) begin
            sro_ff <= 1'b0;
            busy_ff <= 1'b0;
         end
      end
   end

   // probe and phase outputs
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         logic_probe_output <= 1'b0;
         read_active <= 1'b0;
      end else begin
         logic_probe_output <= busy_ff; // [R20]
         read_active <= (st_ff == tbms_pkg::S_READ);
      end
   end
endmodule
`default_nettype wire

// File: rtl/tbms_host.sv
`timescale 1ns/1ps
`include "tbms_regs.svh"
`default_nettype none
module tbms_host #(
   parameter int HCHG_CYC = `TBMS_HCHG_US * `TBMS_MCLK_MHZ,
   parameter int HLCHG_CYC = `TBMS_HLCHG_US * `TBMS_MCLK_MHZ,
   parameter int HSTOP_CYC = `TBMS_HSTOP_US * `TBMS_MCLK_MHZ
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   tbms_link_if.hst lnk
);
   localparam int BIT_CYC = `TBMS_BIT_US * `TBMS_MCLK_MHZ;
   localparam int HALF_CYC = BIT_CYC / 2;
   localparam int SCLK_CYC = `TBMS_HSCLK_US * `TBMS_MCLK_MHZ;

   tbms_pkg::tbms_hstate_t st_ff;
   logic ctl_ff;
   logic [23:0] cnt_ff;
   logic [3:0] n_ff;
   logic [8:0] fsh_ff;
   logic [7:0] ssh_ff;
   logic sdone_ff;
   logic [6:0] mode_ff;
   logic lvl_ff;
   logic [7:0] rxd_ff;
   logic rxv_ff;
   logic aon_ff;
   logic [11:0] atmr_ff;
   logic [3:0] aidx_ff;
   logic [7:0] ash_ff;
   logic adone_ff;
   logic sro_d_ff;
   logic sro;
   logic acc;
   logic cmd_go;

   assign sro = lnk.serial_result_output;
   assign lnk.host_pulse_control_input = ctl_ff;
   assign acc = (avs_read || avs_write) && !avs_waitrequest;
   assign cmd_go = acc && avs_write && avs_address == `TBMS_REG_CMD &&
                   st_ff == tbms_pkg::H_IDLE;

   // bus slave: one wait cycle, then answer
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0;
      end else if ((avs_read || avs_write) && avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
         if (avs_address == `TBMS_REG_STATUS) begin
            avs_readdata <= {29'h0, sro, rxv_ff,
                             st_ff != tbms_pkg::H_IDLE};
         end else if (avs_address == `TBMS_REG_RXDATA) begin
            avs_readdata <= {24'h0, rxd_ff};
         end else if (avs_address == `TBMS_REG_MODE) begin
            avs_readdata <= {25'h0, mode_ff};
         end else if (avs_address == `TBMS_REG_LEVEL) begin
            avs_readdata <= {31'h0, lvl_ff};
         end else begin
            avs_readdata <= 32'h0;
         end
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   // writable registers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         mode_ff <= 7'h0;
         lvl_ff <= 1'b1;
      end else if (acc && avs_write) begin
         if (avs_address == `TBMS_REG_MODE) begin
            mode_ff <= avs_writedata[6:0];
         end else if (avs_address == `TBMS_REG_LEVEL) begin
            lvl_ff <= avs_writedata[0];
         end
      end
   end

   // control line sequencer
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_ff <= tbms_pkg::H_IDLE;
         ctl_ff <= 1'b1;
         cnt_ff <= 24'h0;
         n_ff <= 4'h0;
         fsh_ff <= 9'h0;
         ssh_ff <= 8'h0;
         sdone_ff <= 1'b0;
      end else begin
         sdone_ff <= 1'b0;
         cnt_ff <= cnt_ff - 24'h1;
         n_ff <= 4'h0;
         case (st_ff)
            tbms_pkg::H_IDLE: begin
               ctl_ff <= lvl_ff;
               if (cmd_go && avs_writedata[`TBMS_CMD_FRAME]) begin
                  st_ff <= tbms_pkg::H_FRAME;
                  fsh_ff <= {1'b1, mode_ff, 1'b0};
                  ctl_ff <= 1'b0;
                  cnt_ff <= 24'(BIT_CYC - 1);
               end else if (cmd_go && avs_writedata[`TBMS_CMD_CHARGE]) begin
                  st_ff <= tbms_pkg::H_LOW;
                  ctl_ff <= 1'b0;
                  cnt_ff <= avs_writedata[`TBMS_CMD_LONG] ?
                            24'(HLCHG_CYC - 1) : 24'(HCHG_CYC - 1);
               end else if (cmd_go && avs_writedata[`TBMS_CMD_STOP]) begin
                  st_ff <= tbms_pkg::H_LOW;
                  ctl_ff <= 1'b0;
                  cnt_ff <= 24'(HSTOP_CYC - 1);
               end else if (cmd_go && avs_writedata[`TBMS_CMD_SCLK]) begin
                  st_ff <= tbms_pkg::H_SCLK;
                  ctl_ff <= 1'b0;
                  cnt_ff <= 24'(SCLK_CYC - 1);
               end
            end
            tbms_pkg::H_FRAME: begin
               n_ff <= n_ff;
               if (cnt_ff == 24'h0) begin
                  cnt_ff <= 24'(BIT_CYC - 1);
                  n_ff <= n_ff + 4'h1;
                  fsh_ff <= {1'b1, fsh_ff[8:1]};
                  ctl_ff <= fsh_ff[1];
                  if (n_ff == 4'h8) begin
                     st_ff <= tbms_pkg::H_IDLE;
                     ctl_ff <= lvl_ff;
                  end
               end
            end
            tbms_pkg::H_LOW: begin
               if (cnt_ff == 24'h0) begin
                  st_ff <= tbms_pkg::H_IDLE;
                  ctl_ff <= lvl_ff;
               end
            end
            default: begin
               n_ff <= n_ff;
               if (cnt_ff == 24'h0) begin
                  cnt_ff <= 24'(SCLK_CYC - 1);
                  ctl_ff <= ~ctl_ff;
                  // sample before the rise, the device drops the line on it
                  if (!ctl_ff) begin
                     ssh_ff <= {~sro, ssh_ff[7:1]}; // [R23]
                     n_ff <= n_ff + 4'h1;
                     if (n_ff == 4'h7) begin
                        st_ff <= tbms_pkg::H_IDLE;
                        ctl_ff <= lvl_ff;
                        sdone_ff <= 1'b1;
                     end
                  end
               end
            end
         endcase
      end
   end

   // asynchronous byte receiver
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sro_d_ff <= 1'b0;
         aon_ff <= 1'b0;
         atmr_ff <= 12'h0;
         aidx_ff <= 4'h0;
         ash_ff <= 8'h0;
         adone_ff <= 1'b0;
      end else begin
         sro_d_ff <= sro;
         adone_ff <= 1'b0;
         if (!aon_ff) begin
            if (sro && !sro_d_ff && !mode_ff[`TBMS_MODE_SYNC]) begin
               aon_ff <= 1'b1;
               atmr_ff <= 12'h0;
               aidx_ff <= 4'h0;
            end
         end else begin
            atmr_ff <= atmr_ff + 12'h1;
            if (atmr_ff == 12'(HALF_CYC)) begin
               if (aidx_ff == 4'h9) begin
                  aon_ff <= 1'b0;
                  adone_ff <= 1'b1;
               end else if (aidx_ff != 4'h0) begin
                  ash_ff <= {~sro, ash_ff[7:1]};
               end
            end
            if (atmr_ff == 12'(BIT_CYC - 1)) begin
               atmr_ff <= 12'h0;
               aidx_ff <= aidx_ff + 4'h1;
            end
         end
      end
   end

   // received byte store, new byte wins over read clear
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rxd_ff <= 8'h0;
         rxv_ff <= 1'b0;
      end else if (adone_ff) begin
         rxd_ff <= ash_ff;
         rxv_ff <= 1'b1;
      end else if (sdone_ff) begin
         rxd_ff <= ssh_ff;
         rxv_ff <= 1'b1;
      end else if (acc && avs_read && avs_address == `TBMS_REG_RXDATA) begin
         rxv_ff <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// File: tb/tb_transponder_base_mode_sequencer.sv
`timescale 1ns/1ps
`include "tbms_regs.svh"
`default_nettype none
module tb_transponder_base_mode_sequencer;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic meas_valid = 1'b0;
   logic [7:0] meas_count = 8'h00;
   logic rx_valid = 1'b0;
   logic [7:0] rx_byte = 8'h00;
   logic osc_ok = 1'b1;
   logic short_fault = 1'b0;
   logic carrier_on, threshold_source_select, clocked_output_select;
   logic test_follow, logic_probe_output, read_active;
   logic [7:0] div_factor;
   logic [3:0] threshold_code;
   logic [31:0] rd;
   logic [9:0] slots;
   int miscompares = 0;
   int tests_run = 0;
   always #10 mclk = ~mclk;
   tbms_link_if lnk();
   tbms_device #(.DIAG_CYC(400), .READ_CYC(40000), .SLEEP_CYC(200000),
      .STOP_CYC(500), .WEND_CYC(600), .LCHG_CYC(4000)) tbms_device_i (
      .mclk(mclk), .rst(rst), .lnk(lnk.dev), .meas_valid(meas_valid),
      .meas_count(meas_count), .rx_valid(rx_valid), .rx_byte(rx_byte),
      .osc_ok(osc_ok), .short_fault(short_fault), .carrier_on(carrier_on),
      .div_factor(div_factor),
      .threshold_source_select(threshold_source_select),
      .threshold_code(threshold_code),
      .clocked_output_select(clocked_output_select),
      .test_follow(test_follow), .logic_probe_output(logic_probe_output),
      .read_active(read_active));
   tbms_host #(.HCHG_CYC(30000), .HLCHG_CYC(34000), .HSTOP_CYC(700))
      tbms_host_i (.mclk(mclk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .lnk(lnk.hst));
   tbms_props #(.DIAG_CYC(400)) tbms_props_i (.mclk(mclk), .rst(rst),
      .host_pulse_control_input(lnk.host_pulse_control_input),
      .serial_result_output(lnk.serial_result_output),
      .carrier_on(carrier_on), .read_active(read_active),
      .div_factor(div_factor), .meas_valid(meas_valid),
      .clocked_output_select(clocked_output_select),
      .threshold_source_select(threshold_source_select),
      .logic_probe_output(logic_probe_output));
   task automatic stop_test();
      $display("checks %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                      input string what);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic hang(input int n, input int lim);
      if (n > lim) begin
         miscompares++;
         $display("[ERR] %0t wait ran out", $time);
         stop_test();
      end
   endtask
   // one avalon access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [4:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
         hang(n, 100);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   initial begin
      int n;
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      chk(32'({carrier_on, div_factor, test_follow, clocked_output_select,
         threshold_source_select, threshold_code}),
         32'({`TBMS_DIV_DEF, 7'h00}), "reset");
      chk(32'({lnk.host_pulse_control_input, lnk.serial_result_output}),
         32'h2, "idle lines");
      bus(1'b0, 5'h1c, 32'h0);
      chk(rd, 32'h0, "unmapped read");
      $display("test reset done");
      // divider 1011, AFC threshold source, async, no test byte
      bus(1'b1, `TBMS_REG_MODE, 32'h2b);
      bus(1'b1, `TBMS_REG_CMD, 32'h1 << `TBMS_CMD_FRAME);
      n = 0;
      do begin
         bus(1'b0, `TBMS_REG_STATUS, 32'h0);
         n++;
         hang(n, 20000);
      end while (rd[0] !== 1'b0);
      repeat (10) @(posedge mclk);
      chk(32'({div_factor, threshold_source_select, threshold_code,
         clocked_output_select, test_follow}),
         32'({`TBMS_DIV_124, 7'h6c}), "mode");
      $display("test program done");
      bus(1'b1, `TBMS_REG_CMD, 32'h1 << `TBMS_CMD_CHARGE);
      n = 0;
      do begin
         @(posedge mclk);
         n++;
         hang(n, 60000);
      end while (lnk.serial_result_output !== 1'b1);
      // fault after the byte is latched must not alter it
      osc_ok <= 1'b0;
      short_fault <= 1'b1;
      repeat (1600) @(posedge mclk);
      for (int i = 0; i < 10; i++) begin
         slots[i] = lnk.serial_result_output;
         repeat (3200) @(posedge mclk);
      end
      chk(32'(slots), 32'({1'b0, ~8'haf, 1'b1}), "diag wire");
      bus(1'b0, `TBMS_REG_RXDATA, 32'h0);
      chk(32'(rd[7:0]), 32'haf, "diag byte");
      chk(32'({read_active, lnk.host_pulse_control_input}), 32'h3,
         "read phase");
      rx_byte <= 8'h3c;
      rx_valid <= 1'b1;
      @(posedge mclk);
      rx_valid <= 1'b0;
      repeat (3) @(posedge mclk);
      chk(32'({logic_probe_output, lnk.serial_result_output}), 32'h3,
         "rx byte start");
      bus(1'b1, `TBMS_REG_CMD, 32'h1 << `TBMS_CMD_STOP);
      n = 0;
      do begin
         @(posedge mclk);
         n++;
         hang(n, 3000);
      end while (read_active !== 1'b0);
      // measurement must be ignored outside automatic divider mode
      meas_count <= 8'h70;
      meas_valid <= 1'b1;
      @(posedge mclk);
      meas_valid <= 1'b0;
      repeat (1000) @(posedge mclk);
      chk(32'({read_active, carrier_on, lnk.host_pulse_control_input,
         div_factor}), 32'h17c, "stopped");
      $display("test read done");
      stop_test();
   end
endmodule
`default_nettype wire

// File: tb/tbms_props.sv
`timescale 1ns/1ps
`default_nettype none
module tbms_props #(
   parameter int DIAG_CYC = 400
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic host_pulse_control_input,
   input wire logic serial_result_output,
   input wire logic carrier_on,
   input wire logic read_active,
   input wire logic [7:0] div_factor,
   input wire logic meas_valid,
   input wire logic clocked_output_select,
   input wire logic threshold_source_select,
   input wire logic logic_probe_output
);
   localparam int DLO = DIAG_CYC - 2;
   localparam int DHI = DIAG_CYC + 2;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   reset_vals_a: assert property (
      $fell(rst) |-> div_factor == 8'h77 && !carrier_on && !read_active
         && !serial_result_output && host_pulse_control_input)
      else $error("outputs wrong after reset");
   read_entry_a: assert property (
      $rose(read_active) |-> host_pulse_control_input)
      else $error("read entered with control low");
   start_bit_a: assert property (
      $rose(serial_result_output) && !clocked_output_select
         |-> serial_result_output [*8])
      else $error("async high slot too short");
   stop_hold_a: assert property (
      $fell(serial_result_output) && !clocked_output_select
         |-> !serial_result_output [*8])
      else $error("async low slot too short");
   div_field_a: assert property (
      $changed(div_factor) |-> host_pulse_control_input || $past(meas_valid))
      else $error("divider changed outside load");
   afc_field_a: assert property (
      $changed(threshold_source_select)
         |-> host_pulse_control_input && !read_active)
      else $error("threshold source changed outside load");
   probe_busy_a: assert property (
      $rose(serial_result_output) && !clocked_output_select
         |-> ##[1:3] logic_probe_output)
      else $error("probe not showing encoder busy");
   diag_time_a: assert property (
      $rose(carrier_on) && !host_pulse_control_input
         |-> ##[DLO:DHI] $rose(serial_result_output))
      else $error("diagnosis byte not started on time");
endmodule
`default_nettype wire
